/* rtl/casu_pkg.sv */
// Behaviour
// - Overflow flag follows signed overflow result.
// - Two-bit mask code admits NMI plus levels.
// - Accept source only if level beats mask.
// - Acceptance loads mask with accepted level.
// - Enable clear refuses maskables; entry keeps enable.
// - Half-byte modes pass the H bit out beside the address.
// - Handy mode reuses last address, moves only.
// - Operations use register or immediate only.
// - Word transfers allowed at odd addresses.
// - Register relative adds d8 or d16.
// - Branch target is PC plus displacement, 18-bit.
// - Stack relative adds d4, d8 or d16.
// - Absolute 8/12/16 bits; 18 for branches.
// - RAM short is 8-bit offset from zero.
// - I/O short adds 8-bit offset to base.
// - Strap low plus flag selects expansion mode.
// - Expansion register bits 7-5 gate A8-A17.
// - Expansion maps external ROM and RAM ranges.
// - Processor mode sends program space external.
// - Internal ROM at 04000, RAM at 00000.
// - Special registers fixed at 03F00-03FFF.
// - Status word pushed on entry, restored on return.
`default_nettype none
package casu_pkg;
	localparam logic [17:0] RAM_BASE = 18'h00000;
	localparam logic [17:0] SFR_BASE = 18'h03F00;
	localparam logic [17:0] SFR_TOP = 18'h03FFF;
	localparam logic [17:0] XRAM_BASE = 18'h02F00;
	localparam logic [17:0] XRAM_TOP = 18'h03EFF;
	localparam logic [17:0] ROM_BASE = 18'h04000;
	localparam logic [17:0] ROM_TOP_DEF = 18'h0BFFF;
	localparam logic [17:0] RAM_TOP_DEF = 18'h005FF;
	localparam logic [17:0] XROM_EXP_BASE = 18'h20000;
	localparam logic [17:0] XROM_TOP = 18'h3FFFF;
	localparam logic [7:0] MEMCTL_OFS = 8'h01;
	localparam logic [7:0] EXPCTL_OFS = 8'h0E;
	localparam logic [7:0] CTL_OFS = 8'h20;
	localparam logic [7:0] STAT_OFS = 8'h21;
	localparam logic [7:0] PSW_OFS = 8'h22;
	localparam logic [7:0] EAL_OFS = 8'h23;
	localparam logic [7:0] EAH_OFS = 8'h24;
	localparam logic [7:0] EAU_OFS = 8'h25;
	localparam logic [7:0] ACC_OFS = 8'h26;
	localparam int EXPANSION_ENABLE_FLAG_BIT = 4;
	localparam int PSW_V_BIT = 3;
	localparam int PSW_IM_LO = 4;
	localparam int PSW_MIE_BIT = 6;
	localparam logic [7:0] MEMCTL_RST = 8'hC0;
	localparam logic [7:0] EXPCTL_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	typedef enum logic [3:0] {
		CASU_AM_NONE, CASU_AM_IND, CASU_AM_REL8, CASU_AM_REL16, CASU_AM_SP4, CASU_AM_SP8,
		CASU_AM_SP16, CASU_AM_ABS8, CASU_AM_ABS12, CASU_AM_ABS16, CASU_AM_RAMS, CASU_AM_IOS,
		CASU_AM_HANDY, CASU_AM_PCREL, CASU_AM_ABS18
	} casu_am_t;
	typedef enum logic [1:0] {CASU_OP_ALU, CASU_OP_MOV, CASU_OP_WORD_MOVE_INSTR, CASU_OP_BRANCH} casu_op_t;
	typedef enum logic [2:0] {CASU_DST_NONE, CASU_DST_IROM, CASU_DST_IRAM, CASU_DST_SFR, CASU_DST_EXT} casu_dst_t;
endpackage
`default_nettype wire

/* rtl/casu_top.sv */
`default_nettype none
module casu_top
	import casu_pkg::*;
#(
	parameter logic [17:0] ROM_TOP = ROM_TOP_DEF,
	parameter logic [17:0] RAM_TOP = RAM_TOP_DEF
) (
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic MODE_STRAP_PIN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic ADDR_REQ_I,
	input wire logic [3:0] ADDR_MODE_I,
	input wire logic [1:0] OP_KIND_I,
	input wire logic [15:0] AREG_I,
	input wire logic [15:0] SP_I,
	input wire logic [17:0] PC_I,
	input wire logic [15:0] DISP_I,
	input wire logic DISP_HALF_I,
	input wire logic ALU_VALID_I,
	input wire logic ALU_SIGNED_OVF_I,
	input wire logic IRQ_REQ_I,
	input wire logic [1:0] SOURCE_PRIORITY_LEVEL_I,
	input wire logic NMI_REQ_I,
	input wire logic IRQ_RETURN_I,
	input wire logic [7:0] PSW_POP_I,
	output logic IRQ_ACCEPT_O,
	output logic NMI_ACCEPT_O,
	output logic [7:0] PSW_PUSH_O,
	output logic PSW_PUSH_VALID_O,
	output logic [17:0] EA_O,
	output logic EA_HALF_O,
	output logic EA_VALID_O,
	output logic EA_ILLEGAL_O,
	output logic [2:0] DEST_O,
	output logic EXT_CYCLE_O,
	output logic [17:8] EXT_ADDR_O,
	output logic [9:0] EXT_ADDR_OE_O,
	output logic [1:0] MEM_MODE_O
);
	// Address and status unit of the core. It keeps the status word bits that gate
	// interrupts and record signed overflow, forms the effective address of each data or
	// branch access, and decides which bus (internal ROM, internal RAM, special registers
	// or the external expansion bus) answers the address. All answers are registered, so
	// the decoder sees its result one cycle after it raises a request.
	// The memory mode is fixed by the strap at reset and, in single-chip operation, by the
	// expansion flag that software sets. Addresses that no bus owns in the current mode
	// are reported with no destination and never open an external cycle.
	// The core clock is the only clock; apart from the reset, the strap is the only asynchronous input.
	// Strap synchroniser and capture state. The pin is asynchronous to the core clock, so it
	// passes two flops, and a small counter waits until both are filled before the mode is taken.
	logic strap_s1;
	logic strap_s2;
	logic proc_mode;
	logic [1:0] strap_wait;
	logic [1:0] next_strap_wait;
	logic next_proc_mode;
	// Software visible state, interrupt bookkeeping and the last data address for handy mode.
	logic [7:0] memory_control_reg;
	logic [7:0] expansion_address_ctrl_reg;
	logic [7:0] processor_status_word;
	logic [17:0] handy_address;
	logic [7:0] accept_count;
	logic [7:0] next_memory_control_reg;
	logic [7:0] next_expansion_address_ctrl_reg;
	logic [7:0] next_psw;
	logic [17:0] next_handy_address;
	logic [7:0] next_accept_count;
	logic [7:0] next_rdata;
	logic next_irq_accept;
	logic next_nmi_accept;
	logic [7:0] next_psw_push;
	logic next_psw_push_valid;
	logic [17:0] next_ea;
	logic next_ea_half;
	logic next_ea_valid;
	logic next_ea_illegal;
	logic [2:0] next_dest;
	logic next_ext_cycle;
	logic [9:0] next_ext_oe;
	logic expansion_mode;
	logic [1:0] mask_level;
	logic maskable_irq_enable;
	casu_am_t am;
	casu_op_t op;
	casu_dst_t dst;

	// Decoder codes are cast to the local enums; codes with no meaning fall to the default
	// arm of the address case and are refused there.
	// The mask field and the enable bit are read straight out of the status word.
	assign am = casu_am_t'(ADDR_MODE_I);
	assign op = casu_op_t'(OP_KIND_I);
	assign mask_level = processor_status_word[PSW_IM_LO +: 2];
	assign maskable_irq_enable = processor_status_word[PSW_MIE_BIT];
	// Strap high overrides; otherwise the control flag picks expansion.
	assign expansion_mode = !proc_mode && memory_control_reg[EXPANSION_ENABLE_FLAG_BIT];

	// Strap capture. The mode is frozen on the third edge after reset release, when the
	// second synchroniser stage holds the real pin level rather than its reset value.
	// Sampling once is enough because the board keeps the strap still after reset; a
	// strap that moved later would otherwise switch the decoder under running code.
	always_comb begin
		next_strap_wait = strap_wait;
		next_proc_mode = proc_mode;
		if (strap_wait != 2'h3) begin
			next_strap_wait = strap_wait + 2'h1;
		end
		if (strap_wait == 2'h2) begin
			next_proc_mode = strap_s2;
		end
	end

	// Synchroniser and strap state registers; the second stage is the only reader of the first.
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
			strap_wait <= 2'h0;
			proc_mode <= 1'b0;
		end else begin
			strap_s1 <= MODE_STRAP_PIN_I;
			strap_s2 <= strap_s1;
			strap_wait <= next_strap_wait;
			proc_mode <= next_proc_mode;
		end
	end

	// Register writes, status word update and interrupt gating.
	// Priority inside one cycle is fixed: a software write to the status word is overridden
	// by the overflow update of a finishing ALU operation, and both are overridden by the
	// restore on return from a handler. The non-maskable request is served before any
	// maskable one, and an accept pushes the old status word in the same cycle.
	// Unmapped register writes are dropped without effect.
	always_comb begin
		next_memory_control_reg = memory_control_reg;
		next_expansion_address_ctrl_reg = expansion_address_ctrl_reg;
		next_psw = processor_status_word;
		next_accept_count = accept_count;
		next_irq_accept = 1'b0;
		next_nmi_accept = 1'b0;
		next_psw_push = PSW_PUSH_O;
		next_psw_push_valid = 1'b0;
		if (WR_I) begin
			unique case (ADDR_I)
				MEMCTL_OFS: next_memory_control_reg = WDATA_I;
				EXPCTL_OFS: next_expansion_address_ctrl_reg = WDATA_I;
				PSW_OFS: next_psw = WDATA_I;
				default: ;
			endcase
		end
		// The overflow flag tracks every ALU result, set and clear alike.
		if (ALU_VALID_I) begin
			next_psw[PSW_V_BIT] = ALU_SIGNED_OVF_I;
		end
		// A maskable source needs the enable bit and a level numerically below the mask.
		// Equal levels are refused, which keeps a handler from being entered again by its
		// own source while the mask holds the accepted level.
		if (IRQ_RETURN_I) begin
			next_psw = PSW_POP_I;
		end else if (NMI_REQ_I) begin
			next_nmi_accept = 1'b1;
			next_psw_push = processor_status_word;
			next_psw_push_valid = 1'b1;
			next_accept_count = accept_count + 8'h01;
		end else if (IRQ_REQ_I && maskable_irq_enable
				&& (SOURCE_PRIORITY_LEVEL_I < mask_level)) begin
			next_irq_accept = 1'b1;
			next_psw_push = processor_status_word;
			next_psw_push_valid = 1'b1;
			// Mask takes the accepted level; the enable bit is left alone.
			next_psw[PSW_IM_LO +: 2] = SOURCE_PRIORITY_LEVEL_I;
			next_accept_count = accept_count + 8'h01;
		end
	end

	// Effective address generation and decode.
	// Data addresses are 16 bits and sit in the low 64 KB; only branch forms reach all 18
	// bits, and they carry a half-byte flag beside the address. The handy register follows
	// every legal data access except handy itself, so a chain of handy moves keeps reusing
	// one address. Word moves may start at any byte; the second byte is the next address.
	always_comb begin
		logic [17:0] a;
		logic legal;
		logic [17:0] pcd;
		a = handy_address;
		legal = 1'b1;
		pcd = 18'h00000;
		next_ea_half = 1'b0;
		next_handy_address = handy_address;
		// Each mode forms its address from its own operands; short displacements are
		// sign-extended for address registers and zero-extended for stack offsets.
		// The RAM short and I/O short forms add a byte offset to a fixed base.
		unique case (am)
			CASU_AM_IND: a = {2'b00, AREG_I};
			CASU_AM_REL8: a = {2'b00, AREG_I + {{8{DISP_I[7]}}, DISP_I[7:0]}};
			CASU_AM_REL16: a = {2'b00, AREG_I + DISP_I};
			CASU_AM_SP4: a = {2'b00, SP_I + {12'h000, DISP_I[3:0]}};
			CASU_AM_SP8: a = {2'b00, SP_I + {8'h00, DISP_I[7:0]}};
			CASU_AM_SP16: a = {2'b00, SP_I + DISP_I};
			CASU_AM_ABS8: a = {10'h000, DISP_I[7:0]};
			CASU_AM_ABS12: a = {6'h00, DISP_I[11:0]};
			CASU_AM_ABS16: a = {2'b00, DISP_I};
			CASU_AM_RAMS: a = RAM_BASE + {10'h000, DISP_I[7:0]};
			CASU_AM_IOS: a = SFR_BASE + {10'h000, DISP_I[7:0]};
			CASU_AM_HANDY: begin
				a = handy_address;
				legal = (op == CASU_OP_MOV) || (op == CASU_OP_WORD_MOVE_INSTR);
			end
			CASU_AM_PCREL: begin
				// Displacement is in byte units over the PC; the H bit comes from DISP_HALF_I.
				pcd = {PC_I[17:0]} + {{2{DISP_I[15]}}, DISP_I};
				a = pcd;
				next_ea_half = DISP_HALF_I;
				legal = (op == CASU_OP_BRANCH);
			end
			CASU_AM_ABS18: begin
				a = {1'b0, DISP_I, DISP_HALF_I};
				next_ea_half = DISP_HALF_I;
				legal = (op == CASU_OP_BRANCH);
			end
			CASU_AM_NONE: legal = 1'b1;
			default: legal = 1'b0;
		endcase
		// Operation instructions take no memory operand.
		if (op == CASU_OP_ALU && am != CASU_AM_NONE) begin
			legal = 1'b0;
		end
		// Branches reach memory only through the PC relative and the long absolute forms;
		// a branch in any other memory mode is refused rather than silently mis-targeted.
		if (op == CASU_OP_BRANCH && am != CASU_AM_NONE && am != CASU_AM_PCREL && am != CASU_AM_ABS18) begin
			legal = 1'b0;
		end
		// Destination decode. Special registers win in every mode, then internal RAM.
		// Processor mode ignores internal ROM and sends the whole program space outside.
		// Single-chip and expansion use internal ROM below its reserved top byte; only
		// expansion mode adds the external ROM and RAM windows.
		// Whatever is left has no destination and starts no bus cycle.
		dst = CASU_DST_NONE;
		if (a >= SFR_BASE && a <= SFR_TOP) begin
			dst = CASU_DST_SFR;
		end else if (a >= RAM_BASE && a <= RAM_TOP) begin
			dst = CASU_DST_IRAM;
		end else if (proc_mode) begin
			if ((a >= ROM_BASE && a <= XROM_TOP) || (a >= XRAM_BASE && a <= XRAM_TOP)) begin
				dst = CASU_DST_EXT;
			end
		end else if (a >= ROM_BASE && a < ROM_TOP) begin
			dst = CASU_DST_IROM; // Top ROM byte is reserved.
		end else if (expansion_mode && ((a >= XROM_EXP_BASE && a <= XROM_TOP)
				|| (a >= XRAM_BASE && a <= XRAM_TOP))) begin
			dst = CASU_DST_EXT;
		end
		// Word moves at odd addresses are legal; no alignment check.
		next_ea = a;
		next_ea_valid = ADDR_REQ_I && am != CASU_AM_NONE;
		next_ea_illegal = ADDR_REQ_I && !legal;
		next_dest = ADDR_REQ_I ? dst : CASU_DST_NONE;
		// Single-chip mode never opens an external cycle, because no range above maps to
		// the external destination unless processor or expansion mode is active.
		// Refused requests still report their address but never reach a bus.
		next_ext_cycle = next_ea_valid && legal && dst == CASU_DST_EXT;
		// Branch targets are program addresses and must not disturb the data handy address.
		if (next_ea_valid && legal && am != CASU_AM_HANDY && op != CASU_OP_BRANCH) begin
			next_handy_address = a;
		end
	end

	// Upper address pin enables from the expansion control field.
	// The field plus three gives how many of the ten upper lines leave the chip, counted from A8 up;
	// lines not enabled stay low and free for use as general ports.
	// Processor mode always drives all ten, since program code lives outside.
	always_comb begin
		next_ext_oe = 10'h000;
		if (proc_mode) begin
			next_ext_oe = 10'h3FF;
		end else if (expansion_mode) begin
			next_ext_oe = 10'h3FF >> (3'h7 - expansion_address_ctrl_reg[7:5]);
		end
	end

	// Read-back multiplexer. The data register is loaded only in the cycle after a read
	// strobe and holds zero otherwise, so a stale value never lingers on the bus.
	always_comb begin
		unique case (ADDR_I)
			MEMCTL_OFS: next_rdata = memory_control_reg;
			EXPCTL_OFS: next_rdata = expansion_address_ctrl_reg;
			STAT_OFS: next_rdata = {6'h00, expansion_mode, proc_mode};
			PSW_OFS: next_rdata = processor_status_word;
			EAL_OFS: next_rdata = handy_address[7:0];
			EAH_OFS: next_rdata = handy_address[15:8];
			EAU_OFS: next_rdata = {6'h00, handy_address[17:16]};
			ACC_OFS: next_rdata = accept_count;
			default: next_rdata = ZERO8;
		endcase
		if (!RD_I) begin
			next_rdata = ZERO8;
		end
	end

	// Internal state registers. Reset puts the decoder into single-chip operation with the
	// maskable enable clear, so, unless the strap selects processor mode, no external cycle
	// and no maskable accept can appear before software has set the unit up.
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			memory_control_reg <= MEMCTL_RST;
			expansion_address_ctrl_reg <= EXPCTL_RST;
			processor_status_word <= PSW_RST;
			handy_address <= 18'h00000;
			accept_count <= ZERO8;
		end else begin
			memory_control_reg <= next_memory_control_reg;
			expansion_address_ctrl_reg <= next_expansion_address_ctrl_reg;
			processor_status_word <= next_psw;
			handy_address <= next_handy_address;
			accept_count <= next_accept_count;
		end
	end

	// Output registers. Every port comes straight from a flop so that the timing seen by
	// the decoder and the pins does not depend on the adder and range compare depth.
	// The pin enables and the gated upper address move together in the same cycle.
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RDATA_O <= ZERO8;
			IRQ_ACCEPT_O <= 1'b0;
			NMI_ACCEPT_O <= 1'b0;
			PSW_PUSH_O <= ZERO8;
			PSW_PUSH_VALID_O <= 1'b0;
			EA_O <= 18'h00000;
			EA_HALF_O <= 1'b0;
			EA_VALID_O <= 1'b0;
			EA_ILLEGAL_O <= 1'b0;
			DEST_O <= 3'h0;
			EXT_CYCLE_O <= 1'b0;
			EXT_ADDR_O <= 10'h000;
			EXT_ADDR_OE_O <= 10'h000;
			MEM_MODE_O <= 2'h0;
		end else begin
			RDATA_O <= next_rdata;
			IRQ_ACCEPT_O <= next_irq_accept;
			NMI_ACCEPT_O <= next_nmi_accept;
			PSW_PUSH_O <= next_psw_push;
			PSW_PUSH_VALID_O <= next_psw_push_valid;
			EA_O <= next_ea;
			EA_HALF_O <= next_ea_half;
			EA_VALID_O <= next_ea_valid;
			EA_ILLEGAL_O <= next_ea_illegal;
			DEST_O <= next_dest;
			EXT_CYCLE_O <= next_ext_cycle;
			EXT_ADDR_O <= next_ea[17:8] & next_ext_oe;
			EXT_ADDR_OE_O <= next_ext_oe;
			MEM_MODE_O <= {expansion_mode, proc_mode};
		end
	end
endmodule
`default_nettype wire

/* verif/casu_assertions.sv */
`default_nettype none
module casu_checker
	import casu_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic ADDR_REQ_I,
	input wire logic [3:0] ADDR_MODE_I,
	input wire logic [1:0] OP_KIND_I,
	input wire logic [15:0] AREG_I,
	input wire logic [15:0] DISP_I,
	input wire logic IRQ_REQ_I,
	input wire logic IRQ_ACCEPT_O,
	input wire logic [17:0] EA_O,
	input wire logic EA_VALID_O,
	input wire logic EA_ILLEGAL_O,
	input wire logic [2:0] DEST_O,
	input wire logic EXT_CYCLE_O,
	input wire logic [9:0] EXT_ADDR_OE_O,
	input wire logic [1:0] MEM_MODE_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// Address answers come exactly one cycle after a request and never without one.
	property p_req_answer; ADDR_REQ_I && ADDR_MODE_I != CASU_AM_NONE |=> EA_VALID_O || EA_ILLEGAL_O; endproperty
	a_req_answer: assert property (p_req_answer) else $error("EA answer missing");
	property p_req_quiet; !ADDR_REQ_I |=> !EA_VALID_O; endproperty
	a_req_quiet: assert property (p_req_quiet) else $error("EA valid without request");
	property p_ios; ADDR_REQ_I && ADDR_MODE_I == CASU_AM_IOS && OP_KIND_I == CASU_OP_MOV
		|=> EA_O == SFR_BASE + $past(DISP_I[7:0]); endproperty
	a_ios: assert property (p_ios) else $error("IO short address wrong");
	property p_rams; ADDR_REQ_I && ADDR_MODE_I == CASU_AM_RAMS && OP_KIND_I == CASU_OP_MOV
		|=> EA_O == {10'h000, $past(DISP_I[7:0])}; endproperty
	a_rams: assert property (p_rams) else $error("RAM short address wrong");
	property p_rel16; ADDR_REQ_I && ADDR_MODE_I == CASU_AM_REL16 && OP_KIND_I == CASU_OP_MOV
		|=> EA_O == {2'b00, $past(AREG_I) + $past(DISP_I)}; endproperty
	a_rel16: assert property (p_rel16) else $error("Register relative address wrong");
	property p_alu; ADDR_REQ_I && OP_KIND_I == CASU_OP_ALU && ADDR_MODE_I != CASU_AM_NONE |=> EA_ILLEGAL_O; endproperty
	a_alu: assert property (p_alu) else $error("Operation memory mode not refused");
	property p_sfr; EA_VALID_O && EA_O >= SFR_BASE && EA_O <= SFR_TOP |-> DEST_O == CASU_DST_SFR; endproperty
	a_sfr: assert property (p_sfr) else $error("Special register range misrouted");
	property p_single; MEM_MODE_O == 2'b00 |-> !EXT_CYCLE_O; endproperty
	a_single: assert property (p_single) else $error("External cycle in single chip");
	property p_proc_oe; $past(MEM_MODE_O[0]) && MEM_MODE_O[0] |-> EXT_ADDR_OE_O == 10'h3FF; endproperty
	a_proc_oe: assert property (p_proc_oe) else $error("Processor mode lines not driven");
	property p_irq; IRQ_ACCEPT_O |-> $past(IRQ_REQ_I); endproperty
	a_irq: assert property (p_irq) else $error("Accept without request");
endmodule
bind casu_top casu_checker chk_u (.CORE_CLK_I, .ARST_N_I, .ADDR_REQ_I, .ADDR_MODE_I, .OP_KIND_I, .AREG_I,
	.DISP_I, .IRQ_REQ_I, .IRQ_ACCEPT_O, .EA_O, .EA_VALID_O, .EA_ILLEGAL_O, .DEST_O, .EXT_CYCLE_O,
	.EXT_ADDR_OE_O, .MEM_MODE_O);
`default_nettype wire

/* verif/casu_board_model.sv */
`default_nettype none
module casu_board_model (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic strap_sel_i,
	input wire logic ext_cycle_i,
	output logic strap_o,
	output int ext_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// The strap only follows the board choice while reset holds; external cycles are counted.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_o <= strap_sel_i;
			ext_count_o <= 0;
		end else if (ext_cycle_i) begin
			ext_count_o <= ext_count_o + 1;
		end
	end
endmodule
`default_nettype wire

/* verif/casu_tb_top.sv */
`default_nettype none
module casu_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import casu_pkg::*;
	logic clk, rst_n, ssel, strap, wr, rd, req, alu_v, ovf, irq, nmi, ret, half;
	logic iacc, nacc, pushv, eav, eah, eai, extc, ga, gp;
	logic [7:0] addr, wdata, pop, rdata, push;
	logic [3:0] mode;
	logic [1:0] op, lvl, mm;
	logic [15:0] areg, sp, disp;
	logic [17:0] pc, ea;
	logic [2:0] dst;
	logic [17:8] xa;
	logic [9:0] xoe;
	int extn, fail_count, check_count;
	casu_top dut_u (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .MODE_STRAP_PIN_I(strap), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ADDR_REQ_I(req), .ADDR_MODE_I(mode), .OP_KIND_I(op),
		.AREG_I(areg), .SP_I(sp), .PC_I(pc), .DISP_I(disp), .DISP_HALF_I(half), .ALU_VALID_I(alu_v),
		.ALU_SIGNED_OVF_I(ovf), .IRQ_REQ_I(irq), .SOURCE_PRIORITY_LEVEL_I(lvl), .NMI_REQ_I(nmi),
		.IRQ_RETURN_I(ret), .PSW_POP_I(pop), .IRQ_ACCEPT_O(iacc), .NMI_ACCEPT_O(nacc), .PSW_PUSH_O(push),
		.PSW_PUSH_VALID_O(pushv), .EA_O(ea), .EA_HALF_O(eah), .EA_VALID_O(eav), .EA_ILLEGAL_O(eai),
		.DEST_O(dst), .EXT_CYCLE_O(extc), .EXT_ADDR_O(xa), .EXT_ADDR_OE_O(xoe), .MEM_MODE_O(mm));
	casu_board_model board_u (.core_clk_i(clk), .arst_n_i(rst_n), .strap_sel_i(ssel), .ext_cycle_i(extc),
		.strap_o(strap), .ext_count_o(extn));
	// Clock of 100 ns period.
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		ssel <= s;
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		repeat (4) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a; rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	// One address request; destination 7 skips the route check, ill expects a refusal.
	task automatic eareq(input logic [3:0] m, input logic [1:0] o, input logic [15:0] d, input logic [17:0] e,
		input logic [2:0] t, input logic ill);
		@(posedge clk);
		mode <= m; op <= o; disp <= d; req <= 1;
		@(posedge clk);
		req <= 0;
		#1 chk(eai, ill);
		if (!ill) begin
			chk(eav, 1); chk(ea, e);
			if (t != 3'h7) begin chk(dst, t); chk(extc, t == CASU_DST_EXT); end
		end
	endtask
	// Watches a span of cycles for accepts and status pushes.
	task automatic win(input int n);
		ga = 0; gp = 0;
		repeat (n) begin @(posedge clk); #1 ga |= iacc; gp |= pushv; end
		@(posedge clk);
	endtask
	task automatic t_regs();
		rreg(MEMCTL_OFS, MEMCTL_RST); rreg(EXPCTL_OFS, EXPCTL_RST); rreg(PSW_OFS, PSW_RST);
		wreg(8'hF0, 8'hFF); rreg(8'hF0, ZERO8); chk(mm, 2'b00);
	endtask
	task automatic t_ea();
		areg <= 16'h0100; sp <= 16'h0200;
		eareq(CASU_AM_IOS, CASU_OP_MOV, 16'h0010, 18'h03F10, CASU_DST_SFR, 0);
		eareq(CASU_AM_RAMS, CASU_OP_MOV, 16'h0020, 18'h00020, CASU_DST_IRAM, 0);
		eareq(CASU_AM_REL16, CASU_OP_MOV, 16'h0023, 18'h00123, CASU_DST_IRAM, 0);
		eareq(CASU_AM_SP8, CASU_OP_WORD_MOVE_INSTR, 16'h0005, 18'h00205, CASU_DST_IRAM, 0);
		eareq(CASU_AM_ABS16, CASU_OP_WORD_MOVE_INSTR, 16'h4101, 18'h04101, CASU_DST_IROM, 0);
		eareq(CASU_AM_HANDY, CASU_OP_MOV, 16'h0000, 18'h04101, CASU_DST_IROM, 0);
		eareq(CASU_AM_HANDY, CASU_OP_ALU, 16'h0000, 18'h0, 3'h7, 1);
		pc <= 18'h04000; half <= 1;
		eareq(CASU_AM_PCREL, CASU_OP_BRANCH, 16'h0010, 18'h04010, CASU_DST_IROM, 0); chk(eah, 1);
		eareq(CASU_AM_IND, CASU_OP_BRANCH, 16'h0000, 18'h0, 3'h7, 1);
		half <= 0;
		eareq(CASU_AM_RAMS, CASU_OP_ALU, 16'h0020, 18'h0, 3'h7, 1);
		eareq(CASU_AM_ABS16, CASU_OP_MOV, 16'h3000, 18'h03000, 3'h7, 0);
		chk(extc, 0); chk(extn, 0);
	endtask
	task automatic t_ovf();
		alu_v <= 1; ovf <= 1;
		@(posedge clk);
		alu_v <= 0;
		rreg(PSW_OFS, 8'h08);
		alu_v <= 1; ovf <= 0;
		@(posedge clk);
		alu_v <= 0;
		rreg(PSW_OFS, 8'h00);
	endtask
	task automatic t_irq();
		wreg(PSW_OFS, 8'h60);
		lvl <= 2'd1; irq <= 1;
		win(8); chk(ga, 1); chk(gp, 1);
		rreg(PSW_OFS, 8'h50);
		win(6); chk(ga, 0);
		irq <= 0; ret <= 1; pop <= 8'h00;
		@(posedge clk);
		ret <= 0;
		rreg(PSW_OFS, 8'h00);
		wreg(PSW_OFS, 8'h30);
		lvl <= 2'd0; irq <= 1;
		win(6); chk(ga, 0);
		irq <= 0; nmi <= 1;
		@(posedge clk);
		nmi <= 0;
		#1 chk(nacc, 1); chk(push, 8'h30);
		rreg(ACC_OFS, 8'h02);
	endtask
	task automatic t_exp();
		wreg(MEMCTL_OFS, 8'hD0); rreg(MEMCTL_OFS, 8'hD0); chk(mm, 2'b10);
		eareq(CASU_AM_ABS16, CASU_OP_MOV, 16'h3000, 18'h03000, CASU_DST_EXT, 0);
		wreg(EXPCTL_OFS, 8'hE0); rreg(EXPCTL_OFS, 8'hE0); chk(xoe, 10'h3FF);
		eareq(CASU_AM_ABS16, CASU_OP_MOV, 16'h3100, 18'h03100, CASU_DST_EXT, 0); chk(xa, 10'h031);
		wreg(EXPCTL_OFS, 8'h00); rreg(EXPCTL_OFS, 8'h00); chk(xoe, 10'h007);
	endtask
	task automatic t_proc();
		do_reset(1); #1 chk(mm, 2'b01);
		eareq(CASU_AM_ABS16, CASU_OP_MOV, 16'h4100, 18'h04100, CASU_DST_EXT, 0);
		eareq(CASU_AM_IOS, CASU_OP_MOV, 16'h0005, 18'h03F05, CASU_DST_SFR, 0);
		chk(xoe, 10'h3FF);
	endtask
	initial begin
		rst_n = 0; ssel = 0; wr = 0; rd = 0; req = 0; alu_v = 0; ovf = 0; irq = 0; nmi = 0; ret = 0; half = 0;
		addr = 0; wdata = 0; pop = 0; mode = 0; op = 0; lvl = 0; areg = 0; sp = 0; disp = 0; pc = 0;
		fail_count = 0; check_count = 0;
		do_reset(0);
		t_regs(); t_ea(); t_ovf(); t_irq(); t_exp(); t_proc();
		report_and_stop();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
